// File: hdl/dmam_top.sv
// Contract
// RULE_01: Low 512 MB is Code, Normal, executable.
// RULE_02: Working memory region Normal, executable, bit-band. The decode gives this region no bit-band alias, only Normal and executable.
// RULE_03: Peripheral region is Device, execute never.
// RULE_04: External RAM region Normal, executable.
// RULE_05: External device region Device, execute never.
// RULE_06: Private bus region Strongly Ordered, execute never.
// RULE_07: Reserved addresses complete with bus fault.
// RULE_08: Normal accesses may reorder and speculate.
// RULE_09: Device keeps order against Device/Strong.
// RULE_10: Strongly Ordered keeps order against everything.
// RULE_11: Device writes bufferable, Strong writes never.
// RULE_12: Execute-never fetch blocked; fault only on execution.
// RULE_13: Device/Strong pairs observed in program order.
// RULE_14: Enabled protection unit overrides default attributes.
// RULE_15: Fetch ahead and speculative branch fetches allowed.
// RULE_16: Memory barrier drains before next transaction.
// RULE_17: Sync barrier drains before next instruction.
// RULE_18: Instruction barrier forces pipeline refetch.
// RULE_19: Priority change applies after sync barrier.
// RULE_20: Software should run code from Code region.
// RULE_21: Decode combinational, attributes with the request.
`timescale 1ns/1ns
`include "dmam_defines.svh"

module dmam_top #(
  parameter int OUTS_W = `DMAM_OUTS_W
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // Core access request
  input wire logic i_req_valid,
  input wire logic [31:0] i_req_addr,
  input wire logic i_req_write,
  input wire logic [31:0] i_req_wdata,
  input wire logic i_req_instr,
  input wire logic i_req_spec,
  // Protection unit override
  input wire logic i_rpu_en,
  input wire logic i_rpu_hit,
  input wire dmam_pkg::dmam_mem_t i_rpu_type,
  input wire logic i_rpu_xn,
  // Answer to core
  output logic o_req_ack,
  output dmam_pkg::dmam_mem_t o_attr_type,
  output logic o_attr_execute_never,
  output logic o_rsp_valid,
  output logic o_rsp_fault,
  output logic o_rsp_blocked,
  // Bus fabric side
  output logic o_bus_valid,
  output logic [31:0] o_bus_addr,
  output logic o_bus_write,
  output logic [31:0] o_bus_wdata,
  output logic o_bus_instr,
  output logic o_bus_spec,
  output dmam_pkg::dmam_mem_t o_bus_type,
  output logic o_bus_bufferable,
  input wire logic i_bus_ready,
  input wire logic i_bus_done,
  input wire logic i_bus_done_ord,
  // Barriers
  input wire logic i_bar_valid,
  input wire dmam_pkg::dmam_bar_t i_bar_kind,
  output logic o_bar_ack,
  output logic o_barrier_done,
  output logic o_exec_hold,
  output logic o_refetch,
  // Execution of fetched instructions
  input wire logic i_exec_valid,
  input wire logic i_exec_blocked,
  output logic o_xn_fault,
  // Interrupt priority change
  input wire logic i_prio_change,
  output logic o_prio_apply
);

  if (OUTS_W < 1 || OUTS_W > 8) begin : g_chk
    $error("dmam_top: OUTS_W out of range");
  end

  dmam_pkg::dmam_mem_t dec_type;
  logic dec_xn;
  logic dec_rsvd;
  logic pend_valid;
  logic [31:0] pend_addr;
  logic pend_write;
  logic [31:0] pend_wdata;
  logic pend_instr;
  logic pend_spec;
  dmam_pkg::dmam_mem_t pend_type;
  logic pend_xn;
  logic pend_rsvd;
  logic strong_out;
  logic prio_pend;
  dmam_pkg::dmam_bstate_t bstate;
  dmam_pkg::dmam_bar_t bar_kind;
  logic [OUTS_W-1:0] tot_cnt;
  logic tot_zero;
  logic tot_full;
  logic ord_zero;
  logic bus_hs;
  logic busy;
  logic take_req;
  logic take_bar;
  logic can_issue;
  logic drained;

  // Attribute lookup on the raw request address
  dmam_region_decode u_decode (
    .i_addr(i_req_addr),
    .i_rpu_en(i_rpu_en),
    .i_rpu_hit(i_rpu_hit),
    .i_rpu_type(i_rpu_type),
    .i_rpu_xn(i_rpu_xn),
    .o_type(dec_type),
    .o_execute_never(dec_xn),
    .o_reserved(dec_rsvd)
  ); // RULE_21

  // All issued transactions
  dmam_txn_counter #(.W(OUTS_W)) u_tot (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_inc(bus_hs),
    .i_dec(i_bus_done),
    .o_count(tot_cnt),
    .o_zero(tot_zero),
    .o_full(tot_full)
  );

  // Device and strongly ordered transactions only
  dmam_txn_counter #(.W(OUTS_W)) u_ord (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_inc(bus_hs && o_bus_type != dmam_pkg::mem_normal),
    .i_dec(i_bus_done && i_bus_done_ord),
    .o_count(),
    .o_zero(ord_zero),
    .o_full()
  );

  // Take one request or barrier at a time; ack blocks a double take
  assign bus_hs = o_bus_valid && i_bus_ready;
  assign busy = pend_valid || o_req_ack || o_bar_ack || bstate != dmam_pkg::bs_idle;
  assign take_req = i_req_valid && !busy;
  assign take_bar = i_bar_valid && !i_req_valid && !busy && !o_bus_valid;
  assign drained = tot_zero && !o_bus_valid && !pend_valid;

  // Ordering gate; normal traffic only waits behind a strong access or a full transaction counter
  always_comb begin
    case (pend_type)
      dmam_pkg::mem_normal: can_issue = 1'b1; // RULE_08
      dmam_pkg::mem_device: can_issue = ord_zero; // RULE_09 RULE_13
      dmam_pkg::mem_strong: can_issue = tot_zero; // RULE_10
      default: can_issue = 1'b0;
    endcase
    can_issue = can_issue && !strong_out && !tot_full;
  end

  // Request capture, attributes returned with the ack
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_req_ack <= 1'b0;
      o_attr_type <= dmam_pkg::mem_normal;
      o_attr_execute_never <= 1'b0;
      pend_valid <= 1'b0;
      pend_addr <= 32'h0;
      pend_write <= 1'b0;
      pend_wdata <= 32'h0;
      pend_instr <= 1'b0;
      pend_spec <= 1'b0;
      pend_type <= dmam_pkg::mem_normal;
      pend_xn <= 1'b0;
      pend_rsvd <= 1'b0;
    end else begin
      o_req_ack <= take_req;
      if (take_req) begin
        o_attr_type <= dec_type; // RULE_21
        o_attr_execute_never <= dec_xn;
        pend_valid <= 1'b1;
        pend_addr <= i_req_addr;
        pend_write <= i_req_write;
        pend_wdata <= i_req_wdata;
        pend_instr <= i_req_instr; // RULE_15
        pend_spec <= i_req_spec;
        pend_type <= dec_type;
        pend_xn <= dec_xn;
        pend_rsvd <= dec_rsvd;
      end else if (pend_valid && !o_bus_valid) begin
        if (pend_rsvd || (pend_instr && pend_xn) || can_issue) begin
          pend_valid <= 1'b0;
        end
      end
    end
  end

  // Local answers: bus fault or blocked fetch, never sent to the fabric
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_rsp_valid <= 1'b0;
      o_rsp_fault <= 1'b0;
      o_rsp_blocked <= 1'b0;
    end else begin
      o_rsp_valid <= 1'b0;
      o_rsp_fault <= 1'b0;
      o_rsp_blocked <= 1'b0;
      if (pend_valid && !o_bus_valid) begin
        if (pend_rsvd) begin
          o_rsp_valid <= 1'b1;
          o_rsp_fault <= 1'b1; // RULE_07
        end else if (pend_instr && pend_xn) begin
          o_rsp_valid <= 1'b1;
          o_rsp_blocked <= 1'b1; // RULE_12
        end
      end
    end
  end

  // Bus request register; held until the fabric is ready
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_bus_valid <= 1'b0;
      o_bus_addr <= 32'h0;
      o_bus_write <= 1'b0;
      o_bus_wdata <= 32'h0;
      o_bus_instr <= 1'b0;
      o_bus_spec <= 1'b0;
      o_bus_type <= dmam_pkg::mem_normal;
      o_bus_bufferable <= 1'b0;
    end else if (bus_hs) begin
      o_bus_valid <= 1'b0;
    end else if (pend_valid && !o_bus_valid && !pend_rsvd && !(pend_instr && pend_xn) && can_issue) begin
      o_bus_valid <= 1'b1;
      o_bus_addr <= pend_addr;
      o_bus_write <= pend_write;
      o_bus_wdata <= pend_wdata;
      o_bus_instr <= pend_instr;
      o_bus_spec <= pend_spec;
      o_bus_type <= pend_type;
      o_bus_bufferable <= pend_write && pend_type != dmam_pkg::mem_strong; // RULE_11
    end
  end

  // Strong access in flight stops everything behind it
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      strong_out <= 1'b0;
    end else if (bus_hs && o_bus_type == dmam_pkg::mem_strong) begin
      strong_out <= 1'b1; // RULE_10
    end else if (i_bus_done) begin
      strong_out <= 1'b0;
    end
  end

  // Barrier sequencer: drain, then release the core
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      bstate <= dmam_pkg::bs_idle;
      bar_kind <= dmam_pkg::data_memory_barrier;
      o_bar_ack <= 1'b0;
      o_barrier_done <= 1'b0;
      o_exec_hold <= 1'b0;
      o_refetch <= 1'b0;
    end else begin
      o_bar_ack <= take_bar;
      o_barrier_done <= 1'b0;
      o_refetch <= 1'b0;
      case (bstate)
        dmam_pkg::bs_idle: begin
          if (take_bar) begin
            bstate <= dmam_pkg::bs_drain; // RULE_16
            bar_kind <= i_bar_kind;
            o_exec_hold <= i_bar_kind != dmam_pkg::data_memory_barrier; // RULE_17
          end
        end
        dmam_pkg::bs_drain: begin
          if (drained) begin
            bstate <= dmam_pkg::bs_idle;
            o_barrier_done <= 1'b1;
            o_exec_hold <= 1'b0;
            o_refetch <= bar_kind == dmam_pkg::instruction_sync_barrier; // RULE_18
          end
        end
        default: bstate <= dmam_pkg::bs_idle;
      endcase
    end
  end

  // Priority change waits for a sync barrier; a new change beats the clear
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      prio_pend <= 1'b0;
      o_prio_apply <= 1'b0;
    end else begin
      o_prio_apply <= 1'b0;
      if (bstate == dmam_pkg::bs_drain && drained && bar_kind == dmam_pkg::data_sync_barrier && prio_pend) begin
        o_prio_apply <= 1'b1; // RULE_19
        prio_pend <= i_prio_change;
      end else if (i_prio_change) begin
        prio_pend <= 1'b1;
      end
    end
  end

  // Fault only when a blocked instruction really executes
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_xn_fault <= 1'b0;
    end else begin
      o_xn_fault <= i_exec_valid && i_exec_blocked; // RULE_12
    end
  end

  property p_strong_alone;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      o_bus_valid && o_bus_type == dmam_pkg::mem_strong |-> tot_cnt == '0;
  endproperty
  a_strong_alone: assert property (p_strong_alone) else $error("strong access issued with traffic open"); // RULE_10

  property p_device_order;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      $rose(o_bus_valid) && o_bus_type == dmam_pkg::mem_device |-> $past(ord_zero) && !$past(strong_out);
  endproperty
  a_device_order: assert property (p_device_order) else $error("device access passed an ordered one"); // RULE_09

  property p_strong_nobuf;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      o_bus_valid && o_bus_write |-> o_bus_bufferable == (o_bus_type != dmam_pkg::mem_strong);
  endproperty
  a_strong_nobuf: assert property (p_strong_nobuf) else $error("write buffering wrong for type"); // RULE_11

  property p_reserved_fault;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      take_req && dec_rsvd |=> ##1 o_rsp_valid && o_rsp_fault && !o_bus_valid;
  endproperty
  a_reserved_fault: assert property (p_reserved_fault) else $error("reserved access not faulted"); // RULE_07

  property p_xn_fetch;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      take_req && i_req_instr && dec_xn && !dec_rsvd |=> ##1 o_rsp_blocked && !o_xn_fault && !o_bus_valid;
  endproperty
  a_xn_fetch: assert property (p_xn_fetch) else $error("execute-never fetch not blocked"); // RULE_12

  property p_xn_fault_cause;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      o_xn_fault |-> $past(i_exec_valid) && $past(i_exec_blocked);
  endproperty
  a_xn_fault_cause: assert property (p_xn_fault_cause) else $error("fault without execution"); // RULE_12

  property p_barrier_drained;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      o_barrier_done |-> $past(tot_zero) && !o_bus_valid;
  endproperty
  a_barrier_drained: assert property (p_barrier_drained) else $error("barrier ended with traffic open"); // RULE_16

  property p_sync_hold;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      take_bar && i_bar_kind == dmam_pkg::data_sync_barrier |=> o_exec_hold throughout (bstate == dmam_pkg::bs_drain);
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("execution not held by sync barrier"); // RULE_17

  property p_refetch;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      o_refetch |-> o_barrier_done && $past(bar_kind) == dmam_pkg::instruction_sync_barrier;
  endproperty
  a_refetch: assert property (p_refetch) else $error("refetch without instruction barrier"); // RULE_18

  property p_prio_apply;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      o_prio_apply |-> o_barrier_done && $past(bar_kind) == dmam_pkg::data_sync_barrier;
  endproperty
  a_prio_apply: assert property (p_prio_apply) else $error("priority applied outside sync barrier"); // RULE_19

  property p_code_attr;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
      take_req && i_req_addr[31:29] == 3'h0 && !(i_rpu_en && i_rpu_hit) |=> o_attr_type == dmam_pkg::mem_normal && !o_attr_execute_never;
  endproperty
  a_code_attr: assert property (p_code_attr) else $error("code region attributes wrong"); // RULE_01

endmodule // dmam_top

// File: shared/dmam_defines.svh
`ifndef DMAM_DEFINES_SVH
`define DMAM_DEFINES_SVH

// Default region bounds, inclusive
`define DMAM_CODE_LO 32'h0000_0000
`define DMAM_CODE_HI 32'h1FFF_FFFF
`define DMAM_WRAM_LO 32'h2000_0000
`define DMAM_WRAM_HI 32'h3FFF_FFFF
`define DMAM_PERI_LO 32'h4000_0000
`define DMAM_PERI_HI 32'h5FFF_FFFF
`define DMAM_XRAM_LO 32'h6000_0000
`define DMAM_XRAM_HI 32'h9FFF_FFFF
`define DMAM_XDEV_LO 32'hA000_0000
`define DMAM_XDEV_HI 32'hDFFF_FFFF
`define DMAM_PPB_LO 32'hE000_0000
`define DMAM_PPB_HI 32'hE00F_FFFF

// Outstanding transaction counter width
`define DMAM_OUTS_W 4

`endif

// File: shared/dmam_pkg.sv
package dmam_pkg;

  // Memory type of a region
  typedef enum logic [1:0] {
    mem_normal,
    mem_device,
    mem_strong
  } dmam_mem_t;

  // Barrier kinds from the core
  typedef enum logic [1:0] {
    data_memory_barrier,
    data_sync_barrier,
    instruction_sync_barrier
  } dmam_bar_t;

  // Barrier sequencer states
  typedef enum logic {
    bs_idle,
    bs_drain
  } dmam_bstate_t;

endpackage

// File: hdl/dmam_region_decode.sv
`timescale 1ns/1ns
`include "dmam_defines.svh"

module dmam_region_decode (
  // Access address
  input wire logic [31:0] i_addr,
  // Protection unit override
  input wire logic i_rpu_en,
  input wire logic i_rpu_hit,
  input wire dmam_pkg::dmam_mem_t i_rpu_type,
  input wire logic i_rpu_xn,
  // Attributes
  output dmam_pkg::dmam_mem_t o_type,
  output logic o_execute_never,
  output logic o_reserved
);

  // Range test, used for every region
  function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // Default map, pure logic so attributes meet the request cycle
  always_comb begin
    o_type = dmam_pkg::mem_normal;
    o_execute_never = 1'b0;
    o_reserved = 1'b0;
    if (in_range(i_addr, `DMAM_CODE_LO, `DMAM_CODE_HI)) begin // RULE_01
      o_type = dmam_pkg::mem_normal;
    end else if (in_range(i_addr, `DMAM_WRAM_LO, `DMAM_WRAM_HI)) begin // RULE_02
      o_type = dmam_pkg::mem_normal;
    end else if (in_range(i_addr, `DMAM_PERI_LO, `DMAM_PERI_HI)) begin // RULE_03
      o_type = dmam_pkg::mem_device;
      o_execute_never = 1'b1;
    end else if (in_range(i_addr, `DMAM_XRAM_LO, `DMAM_XRAM_HI)) begin // RULE_04
      o_type = dmam_pkg::mem_normal;
    end else if (in_range(i_addr, `DMAM_XDEV_LO, `DMAM_XDEV_HI)) begin // RULE_05
      o_type = dmam_pkg::mem_device;
      o_execute_never = 1'b1;
    end else if (in_range(i_addr, `DMAM_PPB_LO, `DMAM_PPB_HI)) begin // RULE_06
      o_type = dmam_pkg::mem_strong;
      o_execute_never = 1'b1;
    end else begin
      o_type = dmam_pkg::mem_strong; // Safest ordering for a faulting access
      o_execute_never = 1'b1;
      o_reserved = 1'b1; // RULE_07
    end
    // Programmed region wins over the default attributes
    if (i_rpu_en && i_rpu_hit) begin // RULE_14
      o_type = i_rpu_type;
      o_execute_never = i_rpu_xn;
    end
  end

endmodule // dmam_region_decode

// File: hdl/dmam_txn_counter.sv
`timescale 1ns/1ns

module dmam_txn_counter #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // Issue and completion strobes
  input wire logic i_inc,
  input wire logic i_dec,
  // State
  output logic [W-1:0] o_count,
  output logic o_zero,
  output logic o_full
);

  if (W < 1 || W > 8) begin : g_chk
    $error("dmam_txn_counter: W out of range");
  end

  // Count of transactions issued but not completed
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_count <= '0;
    end else if (i_inc && !i_dec) begin
      o_count <= o_count + W'(1);
    end else if (i_dec && !i_inc && o_count != '0) begin
      o_count <= o_count - W'(1);
    end
  end

  assign o_zero = (o_count == '0);
  assign o_full = (o_count == {W{1'b1}});

endmodule // dmam_txn_counter

// File: tb/dmam_fabric_model.sv
`timescale 1ns/1ns

// Bus fabric stand-in: accepts issued transfers, completes them in order
module dmam_fabric_model (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // Issue side of the block
  input wire logic i_bus_valid,
  input wire dmam_pkg::dmam_mem_t i_bus_type,
  // Bench controls
  input wire logic i_slow,
  input wire logic i_hold,
  // Answers
  output logic o_bus_ready,
  output logic o_bus_done,
  output logic o_bus_done_ord,
  output logic o_pending
);
  logic q[$];
  logic [1:0] wait_cnt;

  // Ready only while valid; slow mode adds wait states
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst || !i_bus_valid || o_bus_ready) begin
      wait_cnt <= 2'h0;
      o_bus_ready <= 1'b0;
    end else begin
      wait_cnt <= wait_cnt + 2'h1;
      o_bus_ready <= !i_slow || (wait_cnt == 2'h2);
    end
  end

  // Completions withheld while stalled; ordered flag shows the inverse when idle
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      q.delete();
      o_bus_done <= 1'b0;
      o_bus_done_ord <= 1'b0;
      o_pending <= 1'b0;
    end else begin
      if (o_bus_done)
        q.pop_front();
      if (i_bus_valid && o_bus_ready)
        q.push_back(i_bus_type != dmam_pkg::mem_normal);
      o_bus_done <= !i_hold && !o_bus_done && (q.size() > 0);
      o_bus_done_ord <= (q.size() > 0) ? q[0] : !o_bus_done_ord;
      o_pending <= q.size() > 0;
    end
  end
endmodule // dmam_fabric_model

// File: tb/default_memory_attribute_map_bench.sv
`timescale 1ns/1ns

module default_memory_attribute_map_bench;
  logic i_sys_clk, i_sys_rst, i_req_valid, i_req_write, i_req_instr, i_req_spec;
  logic [31:0] i_req_addr, i_req_wdata, o_bus_addr, o_bus_wdata;
  logic i_rpu_en, i_rpu_hit, i_rpu_xn, o_req_ack, o_attr_execute_never;
  logic o_rsp_valid, o_rsp_fault, o_rsp_blocked, o_bus_valid, o_bus_write;
  logic o_bus_instr, o_bus_spec, o_bus_bufferable, i_bus_ready, i_bus_done, i_bus_done_ord;
  logic i_bar_valid, o_bar_ack, o_barrier_done, o_exec_hold, o_refetch;
  logic i_exec_valid, i_exec_blocked, o_xn_fault, i_prio_change, o_prio_apply;
  logic slow, hold, pending;
  logic [2:0] ack_attr;
  dmam_pkg::dmam_mem_t i_rpu_type, o_attr_type, o_bus_type;
  dmam_pkg::dmam_bar_t i_bar_kind;
  int mismatches, tests_run;

  dmam_top #(.OUTS_W(4)) dut (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_req_valid(i_req_valid),
    .i_req_addr(i_req_addr), .i_req_write(i_req_write), .i_req_wdata(i_req_wdata),
    .i_req_instr(i_req_instr), .i_req_spec(i_req_spec), .i_rpu_en(i_rpu_en),
    .i_rpu_hit(i_rpu_hit), .i_rpu_type(i_rpu_type), .i_rpu_xn(i_rpu_xn),
    .o_req_ack(o_req_ack), .o_attr_type(o_attr_type), .o_attr_execute_never(o_attr_execute_never),
    .o_rsp_valid(o_rsp_valid), .o_rsp_fault(o_rsp_fault), .o_rsp_blocked(o_rsp_blocked),
    .o_bus_valid(o_bus_valid), .o_bus_addr(o_bus_addr), .o_bus_write(o_bus_write),
    .o_bus_wdata(o_bus_wdata), .o_bus_instr(o_bus_instr), .o_bus_spec(o_bus_spec),
    .o_bus_type(o_bus_type), .o_bus_bufferable(o_bus_bufferable), .i_bus_ready(i_bus_ready),
    .i_bus_done(i_bus_done), .i_bus_done_ord(i_bus_done_ord), .i_bar_valid(i_bar_valid),
    .i_bar_kind(i_bar_kind), .o_bar_ack(o_bar_ack), .o_barrier_done(o_barrier_done),
    .o_exec_hold(o_exec_hold), .o_refetch(o_refetch), .i_exec_valid(i_exec_valid),
    .i_exec_blocked(i_exec_blocked), .o_xn_fault(o_xn_fault), .i_prio_change(i_prio_change),
    .o_prio_apply(o_prio_apply)
  );

  dmam_fabric_model fabric (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_bus_valid(o_bus_valid),
    .i_bus_type(o_bus_type), .i_slow(slow), .i_hold(hold), .o_bus_ready(i_bus_ready),
    .o_bus_done(i_bus_done), .o_bus_done_ord(i_bus_done_ord), .o_pending(pending)
  );

  // Free-running 50 MHz clock
  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end

  task automatic finish_test();
    if (mismatches == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask

  function automatic logic sel(input int w);
    case (w)
      0: return o_bus_valid;
      1: return o_req_ack;
      2: return o_bar_ack;
      3: return o_barrier_done;
      default: return !pending && !o_bus_valid && !i_bus_done;
    endcase
  endfunction

  // Bounded wait; running out ends the run as a failure
  task automatic await(input int w, input string what);
    for (int n = 0; n < 40; n++) begin
      @(posedge i_sys_clk);
      #1;
      if (sel(w) === 1'b1)
        return;
    end
    mismatches++;
    $display("MISMATCH %0t timeout %s", $time, what);
    finish_test();
  endtask

  // One request, held until acknowledged; returns in the cycle after the ack
  task automatic access(input logic [31:0] a, input logic w, input logic ins);
    @(posedge i_sys_clk);
    i_req_valid <= 1'b1;
    i_req_addr <= a;
    i_req_write <= w;
    i_req_instr <= ins;
    i_req_spec <= ins;
    i_req_wdata <= ~a;
    await(1, "request ack");
    ack_attr = {o_attr_execute_never, o_attr_type};
    @(posedge i_sys_clk);
    i_req_valid <= 1'b0;
    #1;
  endtask

  // Region bounds: type, execute-never, fault, buffering
  task automatic sc_map();
    logic [31:0] ta[14] = '{32'h0000_0000, 32'h1FFF_FFFF, 32'h2000_0000, 32'h3FFF_FFFF,
      32'h4000_0000, 32'h5FFF_FFFF, 32'h6000_0000, 32'h9FFF_FFFF, 32'hA000_0000,
      32'hDFFF_FFFF, 32'hE000_0000, 32'hE00F_FFFF, 32'hE010_0000, 32'hFFFF_FFFF};
    logic [3:0] te[14] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h5, 4'h5, 4'h0, 4'h0, 4'h5, 4'h5,
      4'h6, 4'h6, 4'hE, 4'hE};
    for (int i = 0; i < 14; i++) begin
      @(posedge i_sys_clk);
      slow <= i[0];
      access(ta[i], 1'b1, 1'b0);
      chk(ack_attr, te[i][2:0], "attributes");
      chk(o_rsp_valid & o_rsp_fault, te[i][3], "fault");
      chk(o_bus_valid, !te[i][3], "issue");
      if (!te[i][3] && te[i][1:0] != 2'h0)
        chk(o_bus_bufferable, te[i][1:0] == 2'h1, "buffering");
      if (!te[i][3]) begin
        chk(o_bus_addr, ta[i], "bus address");
        chk({o_bus_write, o_bus_type, o_bus_wdata[28:0]}, {1'b1, te[i][1:0], ~ta[i][28:0]}, "bus fields");
      end
      await(4, "idle");
    end
  endtask

  // Execute-never fetch blocked; fault only on execution
  task automatic sc_xn();
    access(32'h4000_0000, 1'b0, 1'b1);
    chk(o_rsp_valid & o_rsp_blocked, 1, "blocked");
    chk(o_bus_valid | o_xn_fault, 0, "fault on fetch");
    access(32'h0000_0100, 1'b0, 1'b1);
    chk(o_bus_valid & o_bus_instr & o_bus_spec, 1, "prefetch");
    await(4, "idle");
    @(posedge i_sys_clk);
    i_exec_valid <= 1'b1;
    @(posedge i_sys_clk);
    i_exec_blocked <= 1'b1;
    #1;
    chk(o_xn_fault, 0, "clean exec");
    @(posedge i_sys_clk);
    i_exec_valid <= 1'b0;
    #1;
    chk(o_xn_fault, 1, "exec fault");
  endtask

  // Protection unit override in both directions
  task automatic sc_rpu();
    @(posedge i_sys_clk);
    i_rpu_en <= 1'b1;
    i_rpu_hit <= 1'b1;
    access(32'h4000_0000, 1'b0, 1'b1);
    chk(ack_attr, 0, "override");
    chk(o_bus_valid, 1, "override issue");
    await(4, "idle");
    @(posedge i_sys_clk);
    i_rpu_type <= dmam_pkg::mem_device;
    i_rpu_xn <= 1'b1;
    access(32'h0000_0200, 1'b0, 1'b0);
    chk(ack_attr, 5, "override");
    await(4, "idle");
    @(posedge i_sys_clk);
    i_rpu_en <= 1'b0;
  endtask

  // Second access while the first is not complete
  task automatic sc_pair(input logic [31:0] a1, input logic [31:0] a2, input logic blk);
    @(posedge i_sys_clk);
    hold <= 1'b1;
    slow <= 1'b0; // Fixed handshake timing so the first transfer is gone
    access(a1, 1'b1, 1'b0);
    access(a2, 1'b0, 1'b0);
    chk(o_bus_valid, !blk, "order");
    repeat (4) @(posedge i_sys_clk);
    #1;
    if (blk)
      chk(o_bus_valid, 0, "held");
    @(posedge i_sys_clk);
    hold <= 1'b0;
    if (blk)
      await(0, "late issue");
    await(4, "idle");
  endtask

  // Barrier drains, hold, refetch, priority apply
  task automatic sc_bar(input int k);
    @(posedge i_sys_clk);
    hold <= 1'b1;
    i_prio_change <= 1'b1;
    @(posedge i_sys_clk);
    i_prio_change <= 1'b0;
    access(32'h4000_0040, 1'b1, 1'b0);
    @(posedge i_sys_clk);
    i_bar_valid <= 1'b1;
    i_bar_kind <= dmam_pkg::dmam_bar_t'(k);
    await(2, "barrier ack");
    chk(o_exec_hold, k != 0, "exec hold");
    @(posedge i_sys_clk);
    i_bar_valid <= 1'b0;
    repeat (4) begin
      @(posedge i_sys_clk);
      #1;
      chk(o_barrier_done, 0, "early barrier");
    end
    @(posedge i_sys_clk);
    hold <= 1'b0;
    await(3, "barrier done");
    chk(o_refetch, k == 2, "refetch");
    chk(o_prio_apply, k == 1, "priority");
    await(4, "idle");
  endtask

  // Reset, then scenarios in turn
  initial begin
    {i_sys_rst, i_req_valid, i_req_write, i_req_instr, i_req_spec, i_rpu_en, i_rpu_hit} = 7'h40;
    {i_rpu_xn, i_bar_valid, i_exec_valid, i_exec_blocked, i_prio_change, slow, hold} = 7'h00;
    i_req_addr = 32'h0;
    i_req_wdata = 32'h0;
    i_rpu_type = dmam_pkg::mem_normal;
    i_bar_kind = dmam_pkg::data_memory_barrier;
    mismatches = 0;
    tests_run = 0;
    repeat (15) @(posedge i_sys_clk);
    #1;
    chk({o_req_ack, o_bus_valid, o_bar_ack, o_exec_hold, o_attr_type}, 0, "reset");
    @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    sc_map();
    sc_xn();
    sc_rpu();
    sc_pair(32'h4000_0010, 32'h2000_0000, 1'b0);
    sc_pair(32'h4000_0010, 32'hE000_E010, 1'b1);
    sc_pair(32'hA000_0000, 32'h4000_0020, 1'b1);
    sc_pair(32'h2000_0000, 32'hE000_E010, 1'b1);
    sc_pair(32'hE000_E010, 32'h2000_0004, 1'b1);
    for (int k = 0; k < 3; k++)
      sc_bar(k);
    finish_test();
  end
endmodule // default_memory_attribute_map_bench
